// ===== include/unf_pkg.sv
// shared constants and carrier types of the nak flag and ep0 size block
package unf_pkg;

  // ---------------------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_EP = 7;

  // ---------------------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_NAK_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_NAK_MASK  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EP0_SIZE  = 8'h08;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned NAK_LSB    = 1;
  localparam int unsigned ZLP_BIT    = 15;
  localparam int unsigned DSET_BIT   = 12;
  localparam int unsigned MAXPKT_W   = 7;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [NUM_EP-1:0]   NAK_FLAGS_RST = 7'h00;
  localparam logic [NUM_EP-1:0]   NAK_MASK_RST  = 7'h00;
  localparam logic [MAXPKT_W-1:0] MAXPKT_RST    = 7'h00;
  localparam logic [DATA_W-1:0]   RDATA_RST     = 32'h0000_0000;
  localparam logic                ZLP_RST       = 1'h0;
  localparam logic                DSET_RST      = 1'h0;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } unf_bus_req_s;

  typedef struct packed {
    logic setup;
    logic fifo_load;
    logic fifo_drain;
    logic zlp_cmd;
    logic zlp_sent;
  } unf_ep0_evt_s;

endpackage : unf_pkg

// ===== hw/unf_nak_bank.sv
// per-endpoint nak flags with mask gating onto one interrupt level
`timescale 1ns/1ps
module unf_nak_bank #(
  parameter int unsigned N = 7
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic [N-1:0] nak_tx_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic [N-1:0] mask_i,
  output logic      [N-1:0] flags_o,
  output logic              irq_o
);
  import unf_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (N < 1 || N > NUM_EP) begin : g_bad_n
    $error("N must lie between 1 and NUM_EP");
  end

  // ---------------------------------------------------------------------------
  // flag per endpoint
  // ---------------------------------------------------------------------------
  for (genvar k = 0; k < N; k++) begin : g_flag
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        flags_o[k] <= NAK_FLAGS_RST[k];
      end else if (nak_tx_i[k]) begin
        // set wins over a clear in the same cycle, masked or not
        flags_o[k] <= 1'b1;
      end else if (clr_i[k]) begin
        flags_o[k] <= 1'b0;
      end
    end
  end

  // mask 0 passes the flag, mask 1 blocks it
  assign irq_o = |(flags_o & ~mask_i);

endmodule : unf_nak_bank

// ===== hw/unf_nak_ep0.sv
// nak flag, nak mask and endpoint-0 packet size registers
//
// Behaviour
// - nak sent on ep1..7 sets its flag
// - mask bit zero passes flag, one blocks
// - masked endpoint still sets flag, no interrupt
// - zlp command sets pending, transmit clears
// - fifo valid bit read only, setup clears
`timescale 1ns/1ps
module unf_nak_ep0 #(
  parameter int unsigned NUM_EP = unf_pkg::NUM_EP
) (
  input  wire logic                        clock_i,
  input  wire logic                        sys_rst_i,
  input  wire unf_pkg::unf_bus_req_s       bus_i,
  output logic [unf_pkg::DATA_W-1:0]       rdata_o,
  input  wire logic [NUM_EP-1:0]           nak_tx_i,
  input  wire unf_pkg::unf_ep0_evt_s       ep0_evt_i,
  output logic                             nak_irq_o,
  output logic [unf_pkg::MAXPKT_W-1:0]     ep0_max_pkt_o,
  output logic                             zero_len_tx_pending_o,
  output logic                             ep0_fifo_valid_o
);
  import unf_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------------------
  if (NUM_EP < 1 || NUM_EP > unf_pkg::NUM_EP) begin : g_bad_num_ep
    $error("NUM_EP must lie between 1 and 7");
  end

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  logic              wr_flags;
  logic              wr_mask;
  logic              wr_size;
  logic [NUM_EP-1:0] wr_field;

  assign wr_field = bus_i.wdata[NAK_LSB +: NUM_EP];

  always_comb begin
    wr_flags = 1'b0;
    wr_mask  = 1'b0;
    wr_size  = 1'b0;
    if (bus_i.wr && bus_i.addr == OFS_NAK_FLAGS) begin
      wr_flags = 1'b1;
    end else if (bus_i.wr && bus_i.addr == OFS_NAK_MASK) begin
      wr_mask = 1'b1;
    end else if (bus_i.wr && bus_i.addr == OFS_EP0_SIZE) begin
      wr_size = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // nak flags and mask
  // ---------------------------------------------------------------------------
  logic [NUM_EP-1:0] nak_mask_per_endpoint_q;
  logic [NUM_EP-1:0] nak_flag_per_endpoint;
  logic [NUM_EP-1:0] nak_clr;

  // software clears a flag by writing one to it
  assign nak_clr = wr_flags ? wr_field : '0;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nak_mask_per_endpoint_q <= NAK_MASK_RST[NUM_EP-1:0];
    end else if (wr_mask) begin
      nak_mask_per_endpoint_q <= wr_field;
    end
  end

  unf_nak_bank #(
    .N (NUM_EP)
  ) unf_nak_bank_i (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .nak_tx_i  (nak_tx_i),
    .clr_i     (nak_clr),
    .mask_i    (nak_mask_per_endpoint_q),
    .flags_o   (nak_flag_per_endpoint),
    .irq_o     (nak_irq_o)
  );

  // ---------------------------------------------------------------------------
  // endpoint-0 size register
  // ---------------------------------------------------------------------------
  logic [MAXPKT_W-1:0] max_pkt_q;
  logic                zero_len_tx_pending_q;
  logic                fifo_valid_q;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      max_pkt_q <= MAXPKT_RST;
    end else if (wr_size) begin
      max_pkt_q <= bus_i.wdata[MAXPKT_W-1:0];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      zero_len_tx_pending_q <= ZLP_RST;
    end else if (ep0_evt_i.zlp_cmd) begin
      zero_len_tx_pending_q <= 1'b1;
    end else if (ep0_evt_i.zlp_sent) begin
      zero_len_tx_pending_q <= 1'b0;
    end
  end

  // a load in the setup cycle wins; the setup clear otherwise empties the bit
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_valid_q <= DSET_RST;
    end else if (ep0_evt_i.fifo_load) begin
      fifo_valid_q <= 1'b1;
    end else if (ep0_evt_i.setup || ep0_evt_i.fifo_drain) begin
      fifo_valid_q <= 1'b0;
    end
  end

  assign ep0_max_pkt_o         = max_pkt_q;
  assign zero_len_tx_pending_o = zero_len_tx_pending_q;
  assign ep0_fifo_valid_o      = fifo_valid_q;

  // ---------------------------------------------------------------------------
  // read path: data stand in the cycle after the strobe only
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (bus_i.rd && bus_i.addr == OFS_NAK_FLAGS) begin
      rdata_d[NAK_LSB +: NUM_EP] = nak_flag_per_endpoint;
    end else if (bus_i.rd && bus_i.addr == OFS_NAK_MASK) begin
      rdata_d[NAK_LSB +: NUM_EP] = nak_mask_per_endpoint_q;
    end else if (bus_i.rd && bus_i.addr == OFS_EP0_SIZE) begin
      rdata_d[ZLP_BIT]          = zero_len_tx_pending_q;
      rdata_d[DSET_BIT]         = fifo_valid_q;
      rdata_d[MAXPKT_W-1:0]     = max_pkt_q;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= RDATA_RST;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  nak_set_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (nak_tx_i != '0) |=> ((nak_flag_per_endpoint & $past(nak_tx_i)) == $past(nak_tx_i)))
    else $error("nak flag not set after nak sent");

  flag_stays_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (nak_flag_per_endpoint != '0 && !wr_flags)
      |=> ((nak_flag_per_endpoint & $past(nak_flag_per_endpoint))
           == $past(nak_flag_per_endpoint)))
    else $error("nak flag dropped without a clear");

  irq_gate_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_mask && (wr_field & nak_flag_per_endpoint) == nak_flag_per_endpoint
     && nak_tx_i == '0) |=> !nak_irq_o)
    else $error("masked flags still raise interrupt");

  masked_set_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ((nak_tx_i & nak_mask_per_endpoint_q) != '0 && !wr_mask)
      |=> ((nak_flag_per_endpoint & $past(nak_tx_i)) == $past(nak_tx_i)))
    else $error("masked endpoint flag not set");

  irq_level_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    nak_irq_o == ((nak_flag_per_endpoint & ~nak_mask_per_endpoint_q) != '0))
    else $error("nak interrupt level mismatch");

  zlp_pend_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ep0_evt_i.zlp_cmd |=> zero_len_tx_pending_o)
    else $error("zero length pending not set");

  zlp_hold_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (zero_len_tx_pending_o && !ep0_evt_i.zlp_sent) |=> zero_len_tx_pending_o)
    else $error("zero length pending not held");

  zlp_clear_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (ep0_evt_i.zlp_sent && !ep0_evt_i.zlp_cmd) |=> !zero_len_tx_pending_o)
    else $error("zero length pending not cleared");

  setup_clr_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (ep0_evt_i.setup && !ep0_evt_i.fifo_load) |=> !ep0_fifo_valid_o)
    else $error("fifo valid not cleared by setup");

  size_write_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_size |=> ep0_max_pkt_o == $past(bus_i.wdata[MAXPKT_W-1:0]))
    else $error("max packet size not stored");

  fifo_load_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ep0_evt_i.fifo_load |=> ep0_fifo_valid_o)
    else $error("fifo valid not set by load");

  mask_write_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_mask |=> nak_mask_per_endpoint_q == $past(wr_field))
    else $error("nak mask not stored");

  flag_clear_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wr_flags |=> (nak_flag_per_endpoint & $past(wr_field & ~nak_tx_i)) == '0)
    else $error("nak flag not cleared by write");

  read_once_a : assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !bus_i.rd |=> rdata_o == '0)
    else $error("read data outside read cycle");

endmodule : unf_nak_ep0

// ===== bench/unf_host_model.sv
// usb host side model raising nak and ep0 event pulses
`timescale 1ns/1ps
module unf_host_model (
  input  wire logic                  clock_i,
  output logic [unf_pkg::NUM_EP-1:0] nak_tx_o,
  output unf_pkg::unf_ep0_evt_s      ep0_evt_o
);
  import unf_pkg::*;
  initial begin
    nak_tx_o = '0;
    ep0_evt_o = '0;
  end
  // ---------------------------------------------------------------------------
  // one-cycle pulses, launched just after an edge
  // ---------------------------------------------------------------------------
  task automatic nak(input logic [NUM_EP-1:0] eps);
    @(posedge clock_i);
    nak_tx_o <= eps;
    @(posedge clock_i);
    nak_tx_o <= '0;
  endtask : nak
  task automatic evt(input unf_ep0_evt_s e);
    @(posedge clock_i);
    ep0_evt_o <= e;
    @(posedge clock_i);
    ep0_evt_o <= '0;
  endtask : evt
endmodule : unf_host_model

// ===== bench/unf_nak_ep0_tb_top.sv
// self-checking bench of the nak flag and ep0 size block
`timescale 1ns/1ps
module unf_nak_ep0_tb_top;
  import unf_pkg::*;
  localparam unf_ep0_evt_s EV_SETUP = 5'b10000;
  localparam unf_ep0_evt_s EV_LOAD  = 5'b01000;
  localparam unf_ep0_evt_s EV_ZCMD  = 5'b00010;
  localparam unf_ep0_evt_s EV_ZSENT = 5'b00001;
  localparam unf_ep0_evt_s EV_DRAIN = 5'b00100;
  localparam unf_ep0_evt_s EV_ZBOTH = 5'b00011;
  localparam unf_ep0_evt_s EV_LDSET = 5'b11000;
  logic                clock_i = 1'b0;
  logic                sys_rst_i = 1'b1;
  unf_bus_req_s        bus = '0;
  logic [DATA_W-1:0]   rdata;
  logic [NUM_EP-1:0]   nak_tx;
  unf_ep0_evt_s        ep0_evt;
  logic                nak_irq;
  logic [MAXPKT_W-1:0] max_pkt;
  logic                zlp_pend;
  logic                fifo_valid;
  int                  failures = 0;
  int                  tests_run = 0;

  always #5 clock_i = ~clock_i;

  unf_nak_ep0 unf_nak_ep0_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
    .nak_tx_i(nak_tx), .ep0_evt_i(ep0_evt), .nak_irq_o(nak_irq),
    .ep0_max_pkt_o(max_pkt), .zero_len_tx_pending_o(zlp_pend),
    .ep0_fifo_valid_o(fifo_valid));
  unf_host_model unf_host_model_i (
    .clock_i(clock_i), .nak_tx_o(nak_tx), .ep0_evt_o(ep0_evt));

  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock_i);
    bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input string n, input logic [DATA_W-1:0] e);
    @(posedge clock_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask : rd
  task automatic close_out;
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_nak;
    wr(OFS_NAK_MASK, 32'h0000_0004);
    rd(OFS_NAK_MASK, "mask", 32'h0000_0004);
    unf_host_model_i.nak(7'h03);
    #1;
    chk("irq ep1", 32'h1, {31'h0, nak_irq});
    rd(OFS_NAK_FLAGS, "flags", 32'h0000_0006);
    wr(OFS_NAK_FLAGS, 32'h0000_0002);
    chk("irq masked", 32'h0, {31'h0, nak_irq});
    wr(OFS_NAK_MASK, 32'h0000_0000);
    chk("irq unmask", 32'h1, {31'h0, nak_irq});
    wr(OFS_NAK_MASK, 32'h0000_00fe);
    unf_host_model_i.nak(7'h7f);
    #1;
    chk("irq all masked", 32'h0, {31'h0, nak_irq});
    rd(OFS_NAK_FLAGS, "flags all", 32'h0000_00fe);
    wr(OFS_NAK_FLAGS, 32'h0000_00fe);
    wr(OFS_NAK_MASK, 32'h0000_0000);
    chk("irq cleared", 32'h0, {31'h0, nak_irq});
    // nak and write-one clear land in the same cycle: the set must win
    fork
      wr(OFS_NAK_FLAGS, 32'h0000_0002);
      unf_host_model_i.nak(7'h01);
    join
    chk("irq set wins", 32'h1, {31'h0, nak_irq});
    rd(OFS_NAK_FLAGS, "flag set wins", 32'h0000_0002);
    wr(OFS_NAK_FLAGS, 32'h0000_0002);
    chk("irq cleared again", 32'h0, {31'h0, nak_irq});
  endtask : t_nak
  task automatic t_zlp;
    unf_host_model_i.evt(EV_ZCMD);
    #1;
    chk("zlp set", 32'h1, {31'h0, zlp_pend});
    rd(OFS_EP0_SIZE, "zlp bit", 32'h0000_8000);
    unf_host_model_i.evt(EV_ZSENT);
    #1;
    chk("zlp clear", 32'h0, {31'h0, zlp_pend});
    unf_host_model_i.evt(EV_ZBOTH);
    #1;
    chk("zlp cmd wins", 32'h1, {31'h0, zlp_pend});
    unf_host_model_i.evt(EV_ZSENT);
    #1;
    chk("zlp sent", 32'h0, {31'h0, zlp_pend});
  endtask : t_zlp
  task automatic t_fifo;
    unf_host_model_i.evt(EV_LOAD);
    wr(OFS_EP0_SIZE, 32'h0000_0000);
    rd(OFS_EP0_SIZE, "valid bit", 32'h0000_1000);
    unf_host_model_i.evt(EV_SETUP);
    #1;
    chk("valid clear", 32'h0, {31'h0, fifo_valid});
    unf_host_model_i.evt(EV_LDSET);
    #1;
    chk("load wins", 32'h1, {31'h0, fifo_valid});
    unf_host_model_i.evt(EV_DRAIN);
    #1;
    chk("drain clear", 32'h0, {31'h0, fifo_valid});
  endtask : t_fifo
  task automatic t_size;
    wr(OFS_EP0_SIZE, 32'hffff_ffff);
    rd(OFS_EP0_SIZE, "size reg", 32'h0000_007f);
    chk("size out", 32'h7f, {25'h0, max_pkt});
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, "unmapped", 32'h0000_0000);
  endtask : t_size

  initial begin
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(OFS_NAK_FLAGS, "flags rst", 32'h0);
    rd(OFS_NAK_MASK, "mask rst", 32'h0);
    rd(OFS_EP0_SIZE, "size rst", 32'h0);
    t_nak();
    t_zlp();
    t_fifo();
    t_size();
    close_out();
  end
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule : unf_nak_ep0_tb_top
